// >>> pkg/hbd_pkg.sv
/*
 * Package for the hall-sensor brushless drive supervisor: thresholds as converter
 * codes, timing counts at a 10 MHz system clock, state encodings and the boot duty.
 * Assumes 12-bit converter codes and a single clock domain.
 */
package hbd_pkg;

    // ******************************************************************
    // Timing
    // ******************************************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int PWM_HZ          = 20_000;
    localparam int MON_US          = 50;
    localparam int HALL_TMO_MS     = 200;
    localparam int DEAD_NS         = 1000;
    localparam int PWM_CYC         = CLK_HZ / PWM_HZ;
    localparam int MON_CYC         = (CLK_HZ / 1_000_000) * MON_US;
    localparam int HALL_TMO_CYC    = (CLK_HZ / 1000) * HALL_TMO_MS;
    localparam int DEAD_CYC        = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ******************************************************************
    // Speed command scaling
    // ******************************************************************
    localparam int RPM_FULL        = 2700;
    localparam int RPM_MIN         = 550;
    localparam int RPM_MAX         = 2650;
    localparam int RPM_OVER        = 3000;
    localparam logic [11:0] POT_MID = 12'h0800;
    localparam logic [11:0] POT_CW_TOP = 12'h07ff;

    // ******************************************************************
    // Voltage and current codes, full scale 0FFFH
    // ******************************************************************
    localparam int ADC_FS          = 4095;
    localparam int VBUS_FS_MV      = 111_000;
    localparam int VBUS_OV_MV      = 28_000;
    localparam int VBUS_UV_MV      = 14_000;
    localparam int IPH_FS_MA       = 25_000;
    localparam int IPH_OC_MA       = 890;
    localparam logic [11:0] VBUS_OV_CODE = 12'((VBUS_OV_MV * ADC_FS) / VBUS_FS_MV);
    localparam logic [11:0] VBUS_UV_CODE = 12'((VBUS_UV_MV * ADC_FS + VBUS_FS_MV - 1)
                                               / VBUS_FS_MV);
    localparam logic [11:0] IPH_ZERO_CODE = 12'h0800;
    localparam logic [11:0] IPH_OC_SPAN  = 12'((IPH_OC_MA * ADC_FS) / IPH_FS_MA);

    // ******************************************************************
    // Modes and boot duty
    // ******************************************************************
    typedef enum logic [1:0] {
        HBD_ST_STOP  = 2'b00,
        HBD_ST_BOOT  = 2'b01,
        HBD_ST_DRIVE = 2'b11,
        HBD_ST_ERROR = 2'b10
    } hbd_state_e;

    localparam logic [8:0] BOOT_DUTY = 9'h0064;
endpackage

// >>> src/hbd_supervisor.sv
/*
 * Supervisor for a 120-degree hall-sensor brushless drive: run decision, speed command
 * scaling, protective stop, commutation and first-60-degree chopping.
 * Assumes synchronous, already-converted 12-bit samples, clean hall levels, and that the
 * speed PI loop supplies a duty; output stage three-state handling is left to the pads.
 */
module hbd_supervisor (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_switch_i,
    input  wire logic        error_reset_i,
    input  wire logic [11:0] speed_pot_i,
    input  wire logic [11:0] bus_voltage_i,
    input  wire logic [11:0] phase_u_current_i,
    input  wire logic [11:0] phase_v_current_i,
    input  wire logic [11:0] phase_w_current_i,
    input  wire logic [2:0]  hall_i,
    input  wire logic        ext_overcurrent_stop_n_i,
    input  wire logic        output_short_i,
    input  wire logic [8:0]  drive_duty_i,
    input  wire logic [11:0] speed_rpm_i,
    output logic      [5:0]  gate_o,
    output logic      [5:0]  gate_oe_o,
    output logic      [11:0] speed_cmd_rpm_o,
    output logic             speed_cmd_ccw_o,
    output logic      [11:0] bus_voltage_dv_o,
    output logic             hall_edge_o,
    output logic      [2:0]  sector_o,
    output hbd_pkg::hbd_state_e state_o,
    output logic      [5:0]  fault_o
);
    import hbd_pkg::*;

    // ******************************************************************
    // Helpers
    // ******************************************************************
    // Sector 1..6 from hall code; 0 marks an illegal pattern (000 or 111).
    function automatic logic [2:0] hall_sector(input logic [2:0] h);
        case (h)
            3'b101:  hall_sector = 3'd1;
            3'b100:  hall_sector = 3'd2;
            3'b110:  hall_sector = 3'd3;
            3'b010:  hall_sector = 3'd4;
            3'b011:  hall_sector = 3'd5;
            3'b001:  hall_sector = 3'd6;
            default: hall_sector = 3'd0;
        endcase
    endfunction

    // Magnitude of a current code against the mid-scale zero, used for three phases.
    function automatic logic [11:0] cur_mag(input logic [11:0] c);
        cur_mag = (c >= IPH_ZERO_CODE) ? 12'(c - IPH_ZERO_CODE) : 12'(IPH_ZERO_CODE - c);
    endfunction

    // ******************************************************************
    // Speed command scaling and clamp
    // ******************************************************************
    logic [10:0] pot_mag;
    logic [23:0] pot_prod;
    logic [11:0] pot_rpm;
    logic        pot_ccw;
    logic        cmd_low;

    always_comb begin
        pot_ccw = speed_pot_i >= POT_MID;
        pot_mag = pot_ccw ? 11'(speed_pot_i - POT_MID) : 11'(POT_CW_TOP - speed_pot_i);
        pot_prod = 24'(pot_mag) * 24'(RPM_FULL);
        pot_rpm = 12'(pot_prod / 24'(POT_CW_TOP));
    end

    assign cmd_low = pot_rpm < 12'(RPM_MIN);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speed_cmd_rpm_o <= 12'h0000;
            speed_cmd_ccw_o <= 1'b0;
        end else begin
            speed_cmd_ccw_o <= pot_ccw;
            if (pot_rpm < 12'(RPM_MIN)) begin
                speed_cmd_rpm_o <= 12'(RPM_MIN);
            end else if (pot_rpm > 12'(RPM_MAX)) begin
                speed_cmd_rpm_o <= 12'(RPM_MAX);
            end else begin
                speed_cmd_rpm_o <= pot_rpm;
            end
        end
    end

    // bus voltage in tenths of a volt
    logic [23:0] vbus_prod;
    assign vbus_prod = 24'(bus_voltage_i) * 24'(VBUS_FS_MV / 100);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_voltage_dv_o <= 12'h0000;
        end else begin
            bus_voltage_dv_o <= 12'(vbus_prod / 24'(ADC_FS));
        end
    end

    // ******************************************************************
    // Monitoring period and protection checks
    // ******************************************************************
    logic [9:0]  mon_cnt_q;
    logic        mon_tick;
    logic [5:0]  trip;
    logic [21:0] hall_tmo_q;
    logic [2:0]  hall_q;
    logic        rotating;
    logic        hw_cut_q;

    assign mon_tick = mon_cnt_q == 10'(MON_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i || mon_tick) begin
            mon_cnt_q <= 10'h000;
        end else begin
            mon_cnt_q <= 10'(mon_cnt_q + 10'h001);
        end
    end

    always_comb begin
        trip[0] = mon_tick && (cur_mag(phase_u_current_i) > IPH_OC_SPAN
                            || cur_mag(phase_v_current_i) > IPH_OC_SPAN
                            || cur_mag(phase_w_current_i) > IPH_OC_SPAN);
        trip[1] = mon_tick && bus_voltage_i > VBUS_OV_CODE;
        trip[2] = mon_tick && bus_voltage_i < VBUS_UV_CODE;
        trip[3] = mon_tick && speed_rpm_i > 12'(RPM_OVER);
        trip[4] = rotating && hall_tmo_q == 22'(HALL_TMO_CYC - 1);
        trip[5] = hall_edge_o && hall_sector(hall_i) == 3'd0;
    end

    // ******************************************************************
    // Hall edges and sector
    // ******************************************************************
    // both edges of each hall line
    assign hall_edge_o = hall_i != hall_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Loading the pins keeps a false hall edge from following reset.
            hall_q   <= hall_i;
            sector_o <= 3'd0;
        end else begin
            hall_q <= hall_i;
            if (hall_edge_o || !rotating) begin
                sector_o <= hall_sector(hall_i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || hall_edge_o || !rotating) begin
            hall_tmo_q <= 22'h00_0000;
        end else if (hall_tmo_q != 22'(HALL_TMO_CYC - 1)) begin
            hall_tmo_q <= 22'(hall_tmo_q + 22'h00_0001);
        end
    end

    // ******************************************************************
    // Run state and latched faults
    // ******************************************************************
    hbd_state_e state_q;
    assign state_o  = state_q;
    assign rotating = state_q == HBD_ST_BOOT || state_q == HBD_ST_DRIVE;

    // faults stay until reset with run inactive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_o <= 6'h00;
        end else if (error_reset_i && run_switch_i) begin
            fault_o <= trip;
        end else begin
            fault_o <= fault_o | trip;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= HBD_ST_STOP;
        end else begin
            case (state_q)
                HBD_ST_STOP: begin
                    if (!run_switch_i && !cmd_low && fault_o == 6'h00 && !hw_cut_q) begin
                        state_q <= HBD_ST_BOOT;
                    end
                end
                HBD_ST_BOOT: begin
                    if (speed_rpm_i >= 12'(RPM_MIN)) begin
                        state_q <= HBD_ST_DRIVE;
                    end
                end
                HBD_ST_DRIVE: begin
                    state_q <= HBD_ST_DRIVE;
                end
                default: begin
                    if (fault_o == 6'h00 && !hw_cut_q) begin
                        state_q <= HBD_ST_STOP;
                    end
                end
            endcase
            if (rotating && (run_switch_i || cmd_low)) begin
                state_q <= HBD_ST_STOP;
            end
            if ((trip != 6'h00 || hw_cut_q) && state_q != HBD_ST_ERROR) begin
                state_q <= HBD_ST_ERROR;
            end
        end
    end

    // Hardware cut is latched so a brief glitch cannot let the stage float back on.
    // external stop or short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hw_cut_q <= 1'b0;
        end else if (!ext_overcurrent_stop_n_i || output_short_i) begin
            hw_cut_q <= 1'b1;
        end else if (error_reset_i && run_switch_i) begin
            hw_cut_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Carrier, commutation and dead time
    // ******************************************************************
    logic [8:0] pwm_cnt_q;
    logic [8:0] duty;
    logic       chop;
    logic [2:0] hi_on;
    logic [2:0] lo_on;

    always_ff @(posedge clk_i) begin
        if (rst_i || pwm_cnt_q == 9'(PWM_CYC - 1)) begin
            pwm_cnt_q <= 9'h000;
        end else begin
            pwm_cnt_q <= 9'(pwm_cnt_q + 9'h001);
        end
    end

    // Odd sectors are the first 60 degrees of each high side's conduction.
    // Parity comes from the sector rather than a toggle on each hall edge, so a
    // missed or doubled edge cannot swap the chopped and the solid halves.

    assign duty = (state_q == HBD_ST_BOOT) ? BOOT_DUTY : drive_duty_i;
    assign chop = pwm_cnt_q < duty;

    // two phases on, high side chopped in its first sector
    always_comb begin
        hi_on = 3'b000;
        lo_on = 3'b000;
        case (sector_o)
            3'd1:    begin hi_on = 3'b001; lo_on = 3'b010; end
            3'd2:    begin hi_on = 3'b001; lo_on = 3'b100; end
            3'd3:    begin hi_on = 3'b010; lo_on = 3'b100; end
            3'd4:    begin hi_on = 3'b010; lo_on = 3'b001; end
            3'd5:    begin hi_on = 3'b100; lo_on = 3'b001; end
            3'd6:    begin hi_on = 3'b100; lo_on = 3'b010; end
            default: begin hi_on = 3'b000; lo_on = 3'b000; end
        endcase
        // Reverse rotation drives the same pair with the current reversed, so every
        // legal sector still energises two phases.
        if (speed_cmd_ccw_o) begin
            {hi_on, lo_on} = {lo_on, hi_on};
        end
        if (!rotating) begin
            hi_on = 3'b000;
            lo_on = 3'b000;
        end else if (sector_o[0] && !chop) begin
            hi_on = 3'b000;
        end
    end

    logic [3:0] dead_q [3];
    logic [2:0] hi_prev_q;
    logic [2:0] lo_prev_q;

    // dead time per phase, polarity per side
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    dead_q[g]    <= 4'(DEAD_CYC);
                    hi_prev_q[g] <= 1'b0;
                    lo_prev_q[g] <= 1'b0;
                    gate_o[g]    <= 1'b1;
                    gate_o[g+3]  <= 1'b0;
                end else begin
                    hi_prev_q[g] <= hi_on[g];
                    lo_prev_q[g] <= lo_on[g];
                    if (hi_on[g] != hi_prev_q[g] || lo_on[g] != lo_prev_q[g]) begin
                        dead_q[g] <= 4'(DEAD_CYC);
                    end else if (dead_q[g] != 4'd0) begin
                        dead_q[g] <= 4'(dead_q[g] - 4'd1);
                    end
                    // A side turns on only after its request has held through the dead time.
                    gate_o[g]   <= ~(hi_on[g] && hi_prev_q[g] && dead_q[g] == 4'd0 && !hw_cut_q);
                    gate_o[g+3] <= lo_on[g] && lo_prev_q[g] && dead_q[g] == 4'd0 && !hw_cut_q;
                end
            end
        end
    endgenerate

    // release the pads on a hardware cut
    assign gate_oe_o = {6{!hw_cut_q}};
endmodule // hbd_supervisor

// >>> test/hbd_supervisor_properties.sv
/* Checker for hbd_supervisor: protective stop, gate, cut and command properties.
   Assumes it is bound to hbd_supervisor and sees only that module's ports. */
module hbd_supervisor_properties (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        run_switch_i,
    input wire logic        error_reset_i,
    input wire logic [11:0] bus_voltage_i,
    input wire logic [11:0] phase_u_current_i,
    input wire logic [11:0] phase_v_current_i,
    input wire logic [11:0] phase_w_current_i,
    input wire logic [2:0]  hall_i,
    input wire logic        ext_overcurrent_stop_n_i,
    input wire logic        output_short_i,
    input wire logic [11:0] speed_rpm_i,
    input wire logic [5:0]  gate_o,
    input wire logic [5:0]  gate_oe_o,
    input wire logic [11:0] speed_cmd_rpm_o,
    input wire logic        hall_edge_o,
    input wire logic [2:0]  sector_o,
    input wire hbd_pkg::hbd_state_e state_o,
    input wire logic [5:0]  fault_o
);
    import hbd_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic run, oc_any, any_f, clr;
    int unsigned quiet_q;
    assign run = state_o inside {HBD_ST_BOOT, HBD_ST_DRIVE};
    // A current is over the limit on either side of the mid-scale zero.
    function automatic logic over_lim(input logic [11:0] c);
        over_lim = c > IPH_ZERO_CODE + IPH_OC_SPAN || c < IPH_ZERO_CODE - IPH_OC_SPAN;
    endfunction
    assign oc_any = over_lim(phase_u_current_i) || over_lim(phase_v_current_i) ||
        over_lim(phase_w_current_i) || !ext_overcurrent_stop_n_i || output_short_i;
    assign any_f = |fault_o;
    assign clr = error_reset_i && run_switch_i;
    // Counts quiet cycles while rotating; a timeout must end the run.
    always_ff @(posedge clk_i) begin
        quiet_q <= (rst_i || !run || hall_edge_o) ? 0 : quiet_q + 1;
    end
    chk_gate_err_off: assert property (
        (state_o == HBD_ST_ERROR) [*3] |-> gate_o == 6'h07) else $error("gates on in error");
    chk_no_shoot: assert property (
        (~gate_o[2:0] & gate_o[5:3]) == 3'h0) else $error("both gates of a leg on");
    chk_cmd_clamp: assert property (
        !$past(rst_i) |-> speed_cmd_rpm_o inside {[550:2650]}) else $error("command out of range");
    chk_hw_cut: assert property (
        !ext_overcurrent_stop_n_i |=> gate_oe_o == 6'h00) else $error("pads not released");
    chk_short_cut: assert property (
        output_short_i |=> gate_oe_o == 6'h00) else $error("pads not released on short");
    chk_switch_stop: assert property (
        run && run_switch_i |=> !run) else $error("switch high did not stop");
    chk_oc_cause: assert property (
        $rose(fault_o[0]) |-> $past(oc_any)) else $error("overcurrent without cause");
    chk_ov_cause: assert property (
        $rose(fault_o[1]) |-> $past(bus_voltage_i) > VBUS_OV_CODE) else $error("bad overvoltage");
    chk_uv_cause: assert property (
        $rose(fault_o[2]) |-> $past(bus_voltage_i) < VBUS_UV_CODE) else $error("bad undervoltage");
    chk_spd_cause: assert property (
        $rose(fault_o[3]) |-> $past(speed_rpm_i) > RPM_OVER) else $error("bad overspeed");
    chk_hall_bad: assert property (
        run && hall_edge_o && hall_i inside {3'h0, 3'h7} |=> fault_o[5] && !run)
        else $error("illegal hall code missed");
    chk_fault_err: assert property (
        $rose(any_f) |-> state_o == HBD_ST_ERROR) else $error("fault without error state");
    chk_err_latch: assert property (
        state_o == HBD_ST_ERROR && !clr |=> state_o == HBD_ST_ERROR) else $error("error left");
    chk_hall_sector: assert property (
        run && hall_edge_o && !(hall_i inside {3'h0, 3'h7}) |=> sector_o inside {[1:6]})
        else $error("sector not resolved");
    chk_hall_tmo: assert property (
        quiet_q > HALL_TMO_CYC + 2 |-> !run) else $error("hall timeout missed");
endmodule // hbd_supervisor_properties

bind hbd_supervisor hbd_supervisor_properties u_hbd_supervisor_properties (.*);

// >>> test/hbd_motor_model.sv
/* Model of the inverter, motor and hall sensors around the supervisor.
   Assumes the rotor steps one sector per step_cyc_i + 1 energised cycles. */
module hbd_motor_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  gate_i,
    input  wire logic [5:0]  gate_oe_i,
    input  wire logic [15:0] step_cyc_i,
    input  wire logic        fast_i,
    input  wire logic        bad_i,
    output logic      [2:0]  hall_o,
    output logic      [11:0] speed_rpm_o
);
    logic [2:0] pos_q;
    logic [15:0] cnt_q, idle_q;
    logic on;
    // Chopping drops torque only briefly, so any live gate counts as drive.
    assign on = (gate_oe_i == 6'h3f) && (gate_i != 6'h07);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_q <= 3'h0;
            cnt_q <= 16'h0000;
        end else if (on && cnt_q >= step_cyc_i) begin
            pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
            cnt_q <= 16'h0000;
        end else if (on) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        idle_q <= (rst_i || on) ? 16'h0000 : (idle_q == 16'hffff ? idle_q : idle_q + 16'h0001);
    end
    assign speed_rpm_o = (idle_q > 16'h07d0) ? 12'h000 : (fast_i ? 12'h0c1c : 12'h04b0);
    always_comb begin
        case (pos_q)
            3'h0: hall_o = 3'h1;
            3'h1: hall_o = 3'h3;
            3'h2: hall_o = 3'h2;
            3'h3: hall_o = 3'h6;
            3'h4: hall_o = 3'h4;
            default: hall_o = 3'h5;
        endcase
        if (bad_i) hall_o = 3'h7;
    end
endmodule // hbd_motor_model

// >>> test/hall_bldc_drive_supervisor_tb_top.sv
/* Testbench for hbd_supervisor: start, stop, scaling, trips and pad cuts.
   Assumes hbd_motor_model stands in for the far side of the drive. */
module hall_bldc_drive_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hbd_pkg::*;
    logic clk = 0, rst = 1, run_sw = 1, err_rst = 0, ext_n = 1, short_c = 0, fast = 0, bad = 0;
    logic [11:0] pot = 12'h0000, vbus = 12'h0375, iu = 12'h0800, iv = 12'h0800, iw = 12'h0800;
    logic [15:0] step = 16'h00c8;
    logic [2:0] hall, sector;
    logic [11:0] spd, cmd, dv;
    logic [5:0] gate, oe, fault;
    logic ccw, h_edge;
    hbd_state_e state;
    int fails = 0, check_count = 0, cyc = 0, edges = 0;
    hbd_supervisor u_hbd_supervisor (
        .clk_i(clk), .rst_i(rst), .run_switch_i(run_sw), .error_reset_i(err_rst),
        .speed_pot_i(pot), .bus_voltage_i(vbus), .phase_u_current_i(iu),
        .phase_v_current_i(iv), .phase_w_current_i(iw), .hall_i(hall),
        .ext_overcurrent_stop_n_i(ext_n), .output_short_i(short_c), .drive_duty_i(9'h0c8),
        .speed_rpm_i(spd), .gate_o(gate), .gate_oe_o(oe), .speed_cmd_rpm_o(cmd),
        .speed_cmd_ccw_o(ccw), .bus_voltage_dv_o(dv), .hall_edge_o(h_edge),
        .sector_o(sector), .state_o(state), .fault_o(fault));
    hbd_motor_model u_hbd_motor_model (
        .clk_i(clk), .rst_i(rst), .gate_i(gate), .gate_oe_i(oe), .step_cyc_i(step),
        .fast_i(fast), .bad_i(bad), .hall_o(hall), .speed_rpm_o(spd));
    always #50 clk = ~clk;
    // The ceiling is about five times the length of the whole sequence.
    always @(posedge clk) begin
        cyc++;
        if (h_edge === 1'b1) edges++;
        if (cyc == 40000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_st(input hbd_state_e s, input int lim);
        for (int i = 0; i < lim && state !== s; i++) @(negedge clk);
        chk("state", 12'(s), 12'(state));
    endtask
    task automatic clear();
        run_sw = 1;
        err_rst = 1;
        cycles(3);
        err_rst = 0;
        cycles(2);
        chk("cleared state", 12'(HBD_ST_STOP), 12'(state));
        chk("cleared faults", 12'h000, 12'(fault));
        chk("pads back", 12'h03f, 12'(oe));
    endtask
    task automatic start();
        pot = 12'h0000;
        run_sw = 0;
        wait_st(HBD_ST_BOOT, 5);
        wait_st(HBD_ST_DRIVE, 400);
    endtask
    task automatic t_scale();
        pot = 12'h07ff;
        run_sw = 0;
        cycles(5);
        chk("zero command refused", 12'(HBD_ST_STOP), 12'(state));
        run_sw = 1;
        pot = 12'h0000;
        cycles(510);
        chk("cw top", 12'h0a5a, cmd);
        chk("cw dir", 12'h000, 12'(ccw));
        pot = 12'h0fff;
        vbus = 12'h0fff;
        cycles(510);
        chk("ccw top", 12'h0a5a, cmd);
        chk("ccw dir", 12'h001, 12'(ccw));
        chk("bus full", 12'h0456, dv);
        vbus = 12'h0000;
        cycles(510);
        chk("bus zero", 12'h000, dv);
        vbus = 12'h0375;
        clear();
        $display("scale test done");
    endtask
    task automatic t_run(input logic [15:0] per, input logic [11:0] p);
        step = per;
        start();
        pot = p;
        edges = 0;
        cycles(2000);
        chk("direction", 12'(p[11]), 12'(ccw));
        chk("sector", 12'h001, 12'(sector inside {[3'h1:3'h6]}));
        chk("hall edges seen", 12'h001, 12'(edges > 4));
        pot = 12'h07ff;
        wait_st(HBD_ST_STOP, 5);
        start();
        run_sw = 1;
        wait_st(HBD_ST_STOP, 5);
        $display("run test done");
    endtask
    task automatic t_trip(input int k);
        start();
        case (k)
            0: iv = 12'h0900;
            1: vbus = 12'h0600;
            2: vbus = 12'h0100;
            3: fast = 1;
            default: bad = 1;
        endcase
        wait_st(HBD_ST_ERROR, 1200);
        cycles(3);
        chk("fault bit", 12'h001 << k, 12'(fault));
        chk("gates off", 12'h007, 12'(gate));
        err_rst = 1;
        cycles(3);
        chk("latched", 12'(HBD_ST_ERROR), 12'(state));
        err_rst = 0;
        iv = 12'h0800;
        vbus = 12'h0375;
        fast = 0;
        bad = 0;
        clear();
        $display("trip test %0d done", k);
    endtask
    task automatic t_cut();
        start();
        ext_n = 0;
        cycles(1);
        ext_n = 1;
        chk("cut on stop input", 12'h000, 12'(oe));
        cycles(5);
        chk("cut held", 12'h000, 12'(oe));
        clear();
        start();
        short_c = 1;
        cycles(1);
        short_c = 0;
        chk("cut on short", 12'h000, 12'(oe));
        clear();
        $display("cut test done");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        cycles(2);
        chk("reset gates", 12'h007, 12'(gate));
        chk("reset pads", 12'h03f, 12'(oe));
        chk("reset state", 12'(HBD_ST_STOP), 12'(state));
        $display("reset test done");
        t_scale();
        t_run(16'h00c8, 12'h0000);
        t_run(16'h0028, 12'h0fff);
        t_trip(0);
        t_trip(1);
        t_trip(2);
        t_trip(3);
        t_trip(5);
        t_cut();
        test_done();
    end
endmodule // hall_bldc_drive_supervisor_tb_top
